// [logic/plc_ctrl.sv]
// Loop control, lock indication and fallback supervisor with APB registers
// Function
// - Reference divides crystal by 1..8; loop multiplies reference by 1..64.
// - Selected loop keeps running during wait mode.
// - Loop suspended in stop unless in fallback; resumes when stop ends, in either bandwidth mode.
// - Lock detector compares feedback and reference frequency windows.
// - Tracking-select reads zero while filter is in acquisition.
// - Filter tracks when not acquiring or tracking-select is one.
// - Automatic mode: detector switches filter, tracking-select read only.
// - Automatic mode: tracking set inside tracking tolerance, cleared outside untracking.
// - Read-only lock bit with lock and unlock tolerances, both modes.
// - Lock interrupt on each lock toggle when lock enable is one.
// - Manual mode: tracking-select writable and steers filter.
// - Fallback mode needs loop supply; at power-up normal modes only.
// - Clock loss detected when either monitor enable is set.
// - Fallback disabled plus monitoring: clock loss resets, latched until clock returns.
// - Fallback on clock loss forces loop on, bus-from-loop high, module select low.
// - Fallback flag set in fallback; any change sets irq flag.
// - In fallback monitor forced on, tick, debug, module, e clocks to minimum.
// - In fallback clock monitor polled at mid-count 4096 of 13-stage counter.
// - On clock return leave fallback, restore selects, relock if auto and bus-from-loop.
// - Any reset sets monitor enable and loop on, clears fallback disable.
// - Power-on without clock: counter on oscillator, reset ends at 4096.
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "plc_defines.svh"

module plc_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic loop_supply,
    input wire logic normal_mode,
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic clock_present,
    input wire logic lock_window_raw,
    input wire logic track_window_raw,
    input wire logic tick_enable,
    output logic loop_enable,
    output logic filter_tracking,
    output logic bus_clock_from_loop,
    output logic module_clock_select,
    output logic min_freq_clocks,
    output logic monitor_active,
    output logic monitor_reset,
    output logic internal_reset,
    output logic [2:0] ref_divide,
    output logic [5:0] loop_multiply,
    output logic lock_irq,
    output logic fallback_irq
);

    // ****************************************
    // Synchronisers
    // ****************************************
    logic [2:0] sync1_q, sync2_q;
    logic [2:0] raw_in;
    assign raw_in = {clock_present, track_window_raw, lock_window_raw};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate
    logic lock_s, track_s, clk_s;
    assign lock_s = sync2_q[0];
    assign track_s = sync2_q[1];
    assign clk_s = sync2_q[2];

    // ****************************************
    // State
    // ****************************************
    logic [9:0] ctrl_q, ctrl_d;
    logic [5:0] syn_q, syn_d;
    logic [2:0] refdv_q, refdv_d;
    logic lockif_q, lockif_d, fallback_irq_flag_q, fallback_irq_flag_d;
    logic lock_q, lock_d, trk_q, trk_d;
    logic [12:0] cnt_q, cnt_d;
    logic latch_q, latch_d;
    logic bus_clock_from_loop_sv_q, bus_clock_from_loop_sv_d, mcs_sv_q, mcs_sv_d;
    plc_pkg::plc_state_t st_q, st_d;

    logic wr, rd, mid, fallback, mon_en, lh_ok;
    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;
    assign mid = tick_enable && (cnt_q == (`PLC_CNT_MID - 13'h0001));
    assign fallback = (st_q == plc_pkg::PLC_FALLBACK);
    assign lh_ok = loop_supply && !ctrl_q[`PLC_CTRL_NOLH];
    assign mon_en = ctrl_q[`PLC_CTRL_MON] || ctrl_q[`PLC_CTRL_FMON] || fallback;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        ctrl_d = ctrl_q;
        syn_d = syn_q;
        refdv_d = refdv_q;
        lockif_d = lockif_q;
        fallback_irq_flag_d = fallback_irq_flag_q;
        lock_d = lock_s;
        trk_d = track_s;
        cnt_d = cnt_q;
        latch_d = latch_q;
        bus_clock_from_loop_sv_d = bus_clock_from_loop_sv_q;
        mcs_sv_d = mcs_sv_q;
        st_d = st_q;
        if (tick_enable) begin
            cnt_d = cnt_q + 13'h0001;
        end
        if (wr) begin
            case (paddr)
                `PLC_OFF_CTRL: begin
                    ctrl_d = pwdata[9:0];
                    if (ctrl_q[`PLC_CTRL_AUTO] && pwdata[`PLC_CTRL_AUTO]) begin
                        ctrl_d[`PLC_CTRL_TRK] = ctrl_q[`PLC_CTRL_TRK];
                    end
                end
                `PLC_OFF_SYN: syn_d = pwdata[5:0];
                `PLC_OFF_REFDV: refdv_d = pwdata[2:0];
                `PLC_OFF_FLAG: begin
                    if (pwdata[`PLC_FLG_LOCKIF]) begin
                        lockif_d = 1'b0;
                    end
                    if (pwdata[`PLC_FLG_FALLBACK_IRQ_FLAG]) begin
                        fallback_irq_flag_d = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (ctrl_d[`PLC_CTRL_AUTO]) begin
            ctrl_d[`PLC_CTRL_TRK] = trk_q;
        end
        if (lock_q != lock_s) begin
            lockif_d = 1'b1;
        end
        case (st_q)
            plc_pkg::PLC_POR: begin
                if (cnt_q == `PLC_CNT_MID) begin
                    cnt_d = 13'h0000;
                    if (clk_s) begin
                        st_d = plc_pkg::PLC_RUN;
                    end else if (loop_supply && normal_mode) begin
                        st_d = plc_pkg::PLC_FALLBACK;
                        bus_clock_from_loop_sv_d = ctrl_q[`PLC_CTRL_BUS_CLOCK_FROM_LOOP];
                        mcs_sv_d = ctrl_q[`PLC_CTRL_MCS];
                        fallback_irq_flag_d = 1'b1;
                    end
                end
            end
            plc_pkg::PLC_RUN: begin
                if (mon_en && !clk_s && !stop_mode) begin
                    if (lh_ok) begin
                        st_d = plc_pkg::PLC_FALLBACK;
                        bus_clock_from_loop_sv_d = ctrl_q[`PLC_CTRL_BUS_CLOCK_FROM_LOOP];
                        mcs_sv_d = ctrl_q[`PLC_CTRL_MCS];
                        fallback_irq_flag_d = 1'b1;
                    end else begin
                        st_d = plc_pkg::PLC_MONRST;
                        latch_d = 1'b1;
                    end
                end
            end
            plc_pkg::PLC_FALLBACK: begin
                if (mid && clk_s) begin
                    st_d = plc_pkg::PLC_RUN;
                    ctrl_d[`PLC_CTRL_BUS_CLOCK_FROM_LOOP] = bus_clock_from_loop_sv_q;
                    ctrl_d[`PLC_CTRL_MCS] = mcs_sv_q;
                    fallback_irq_flag_d = 1'b1;
                end else begin
                    if (wr && paddr == `PLC_OFF_CTRL) begin
                        bus_clock_from_loop_sv_d = pwdata[`PLC_CTRL_BUS_CLOCK_FROM_LOOP];
                        mcs_sv_d = pwdata[`PLC_CTRL_MCS];
                    end
                end
            end
            plc_pkg::PLC_MONRST: begin
                ctrl_d = `PLC_CTRL_RST;
                if (clk_s) begin
                    st_d = plc_pkg::PLC_RUN;
                    latch_d = 1'b0;
                end
            end
            default: st_d = plc_pkg::PLC_POR;
        endcase
        if (!loop_supply) begin
            ctrl_d[`PLC_CTRL_NOLH] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `PLC_CTRL_RST;
            syn_q <= 6'h00;
            refdv_q <= 3'h0;
            lockif_q <= 1'b0;
            fallback_irq_flag_q <= 1'b0;
            lock_q <= 1'b0;
            trk_q <= 1'b0;
            cnt_q <= 13'h0000;
            latch_q <= 1'b0;
            bus_clock_from_loop_sv_q <= 1'b0;
            mcs_sv_q <= 1'b0;
            st_q <= plc_pkg::PLC_POR;
        end else begin
            ctrl_q <= ctrl_d;
            syn_q <= syn_d;
            refdv_q <= refdv_d;
            lockif_q <= lockif_d;
            fallback_irq_flag_q <= fallback_irq_flag_d;
            lock_q <= lock_d;
            trk_q <= trk_d;
            cnt_q <= cnt_d;
            latch_q <= latch_d;
            bus_clock_from_loop_sv_q <= bus_clock_from_loop_sv_d;
            mcs_sv_q <= mcs_sv_d;
            st_q <= st_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic loop_run;
    assign loop_run = (ctrl_q[`PLC_CTRL_LOOP_ON] || fallback) && !(stop_mode && !fallback);
    assign loop_enable = loop_run;
    assign filter_tracking = ctrl_q[`PLC_CTRL_TRK];
    assign bus_clock_from_loop = ctrl_q[`PLC_CTRL_BUS_CLOCK_FROM_LOOP] || fallback || st_q == plc_pkg::PLC_POR;
    assign module_clock_select = ctrl_q[`PLC_CTRL_MCS] && !fallback && st_q != plc_pkg::PLC_POR;
    assign min_freq_clocks = fallback || st_q == plc_pkg::PLC_POR;
    assign monitor_active = mon_en;
    assign monitor_reset = latch_q;
    assign internal_reset = (st_q == plc_pkg::PLC_POR) || latch_q;
    assign ref_divide = refdv_q;
    assign loop_multiply = syn_q;
    assign lock_irq = lockif_q && ctrl_q[`PLC_CTRL_LKIE];
    assign fallback_irq = fallback_irq_flag_q && ctrl_q[`PLC_CTRL_FALLBACK_IRQ_ENABLE];
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    always_comb begin
        prdata = 32'h00000000;
        if (rd) begin
            case (paddr)
                `PLC_OFF_CTRL: prdata = {22'h000000, ctrl_q};
                `PLC_OFF_SYN: prdata = {26'h0000000, syn_q};
                `PLC_OFF_REFDV: prdata = {29'h00000000, refdv_q};
                `PLC_OFF_FLAG: prdata = {28'h0000000, fallback, lock_q, fallback_irq_flag_q, lockif_q};
                `PLC_OFF_STAT: prdata = {29'h00000000, latch_q, st_q};
                default: prdata = 32'h00000000;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_refdv_write:
        assert property (@(posedge pclk) disable iff (!presetn) (wr && paddr == `PLC_OFF_REFDV) |=> ref_divide == $past(pwdata[2:0]))
        else $error("divider write lost");
    a_syn_write:
        assert property (@(posedge pclk) disable iff (!presetn) (wr && paddr == `PLC_OFF_SYN) |=> loop_multiply == $past(pwdata[5:0]))
        else $error("multiplier write lost");
    a_wait_loop:
        assert property (@(posedge pclk) disable iff (!presetn) (wait_mode && !stop_mode && ctrl_q[`PLC_CTRL_LOOP_ON]) |-> loop_enable)
        else $error("loop stopped in wait");
    a_stop_loop:
        assert property (@(posedge pclk) disable iff (!presetn) (stop_mode && !fallback) |-> !loop_enable)
        else $error("loop ran in stop");

    // ****************************************
    // Checks on lock and filter
    // ****************************************
    a_lock_irq_set:
        assert property (@(posedge pclk) disable iff (!presetn) (lock_q != $past(lock_q) && $past(presetn)) |-> lockif_q)
        else $error("lock toggle missed");
    a_lockif_hold:
        assert property (@(posedge pclk) disable iff (!presetn)
            (lockif_q && !(wr && paddr == `PLC_OFF_FLAG && pwdata[`PLC_FLG_LOCKIF])) |=> lockif_q)
        else $error("lock flag dropped");
    a_lock_sync:
        assert property (@(posedge pclk) disable iff (!presetn) lock_q == $past(lock_window_raw, 3))
        else $error("lock sync depth wrong");
    a_trk_sync:
        assert property (@(posedge pclk) disable iff (!presetn) trk_q == $past(track_window_raw, 3))
        else $error("tracking sync depth wrong");
    a_auto_trk:
        assert property (@(posedge pclk) disable iff (!presetn)
            ctrl_q[`PLC_CTRL_AUTO] |-> ##1 (ctrl_q[`PLC_CTRL_TRK] == $past(trk_q) || !ctrl_q[`PLC_CTRL_AUTO]))
        else $error("tracking indicator wrong");
    a_acq_zero:
        assert property (@(posedge pclk) disable iff (!presetn)
            (ctrl_q[`PLC_CTRL_AUTO] && !trk_q) |=> (!filter_tracking || !ctrl_q[`PLC_CTRL_AUTO]))
        else $error("acquisition not reading zero");
    a_manual_trk:
        assert property (@(posedge pclk) disable iff (!presetn)
            (wr && paddr == `PLC_OFF_CTRL && !ctrl_q[`PLC_CTRL_AUTO] && !pwdata[`PLC_CTRL_AUTO]
            && st_q == plc_pkg::PLC_RUN) |=> filter_tracking == $past(pwdata[`PLC_CTRL_TRK]))
        else $error("manual tracking write lost");

    // ****************************************
    // Checks on fallback
    // ****************************************
    a_fallback_forces:
        assert property (@(posedge pclk) disable iff (!presetn)
            fallback |-> (bus_clock_from_loop && !module_clock_select && loop_enable && monitor_active))
        else $error("fallback forcing wrong");
    a_fb_min_clocks:
        assert property (@(posedge pclk) disable iff (!presetn) fallback |-> (min_freq_clocks && monitor_active))
        else $error("fallback clocks wrong");
    a_fallback_flag:
        assert property (@(posedge pclk) disable iff (!presetn) $changed(fallback) |=> fallback_irq_flag_q)
        else $error("fallback change missed");
    a_fallback_irq_flag_hold:
        assert property (@(posedge pclk) disable iff (!presetn)
            (fallback_irq_flag_q && !(wr && paddr == `PLC_OFF_FLAG && pwdata[`PLC_FLG_FALLBACK_IRQ_FLAG])) |=> fallback_irq_flag_q)
        else $error("fallback flag dropped");
    a_exit_at_mid:
        assert property (@(posedge pclk) disable iff (!presetn) (fallback && !mid) |=> fallback)
        else $error("fallback left off poll");
    a_exit_restores:
        assert property (@(posedge pclk) disable iff (!presetn) (fallback && mid && clk_s)
            |=> (ctrl_q[`PLC_CTRL_BUS_CLOCK_FROM_LOOP] == $past(bus_clock_from_loop_sv_q) && ctrl_q[`PLC_CTRL_MCS] == $past(mcs_sv_q)))
        else $error("selects not restored");
    a_loss_leaves_run:
        assert property (@(posedge pclk) disable iff (!presetn)
            (st_q == plc_pkg::PLC_RUN && mon_en && !clk_s && !stop_mode) |=> st_q != plc_pkg::PLC_RUN)
        else $error("clock loss ignored");
    a_no_supply_fb:
        assert property (@(posedge pclk) disable iff (!presetn) (!loop_supply && !fallback) |=> !fallback)
        else $error("fallback without supply");

    // ****************************************
    // Checks on reset and loop supply
    // ****************************************
    a_supply_nolh:
        assert property (@(posedge pclk) disable iff (!presetn) !loop_supply |=> ctrl_q[`PLC_CTRL_NOLH])
        else $error("fallback disable not forced");
    a_mon_reset_hold:
        assert property (@(posedge pclk) disable iff (!presetn) (latch_q && !clk_s) |=> latch_q)
        else $error("monitor reset dropped early");
    a_mon_reset_exit:
        assert property (@(posedge pclk) disable iff (!presetn)
            (st_q == plc_pkg::PLC_MONRST && clk_s) |=> (!latch_q && st_q == plc_pkg::PLC_RUN))
        else $error("monitor reset not released");
    a_reset_defaults:
        assert property (@(posedge pclk) disable iff (!presetn)
            (st_q == plc_pkg::PLC_MONRST) |=> ctrl_q[`PLC_CTRL_MON] && ctrl_q[`PLC_CTRL_LOOP_ON])
        else $error("reset defaults wrong");
    a_por_end:
        assert property (@(posedge pclk) disable iff (!presetn)
            (st_q == plc_pkg::PLC_POR && cnt_q != `PLC_CNT_MID) |=> st_q == plc_pkg::PLC_POR)
        else $error("power-on period ended early");
    a_por_to_run:
        assert property (@(posedge pclk) disable iff (!presetn)
            (st_q == plc_pkg::PLC_POR && cnt_q == `PLC_CNT_MID && clk_s) |=> st_q == plc_pkg::PLC_RUN)
        else $error("power-on exit wrong");

endmodule // plc_ctrl
`default_nettype wire

// [logic/plc_defines.svh]
// Constants for the loop and fallback clock control block
`ifndef PLC_DEFINES_SVH
`define PLC_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PLC_OFF_CTRL 12'h000
`define PLC_OFF_SYN 12'h004
`define PLC_OFF_REFDV 12'h008
`define PLC_OFF_FLAG 12'h00c
`define PLC_OFF_STAT 12'h010

// ****************************************
// Control register fields
// ****************************************
`define PLC_CTRL_LOOP_ON 0
`define PLC_CTRL_AUTO 1
`define PLC_CTRL_TRK 2
`define PLC_CTRL_BUS_CLOCK_FROM_LOOP 3
`define PLC_CTRL_MCS 4
`define PLC_CTRL_NOLH 5
`define PLC_CTRL_MON 6
`define PLC_CTRL_FMON 7
`define PLC_CTRL_LKIE 8
`define PLC_CTRL_FALLBACK_IRQ_ENABLE 9

// ****************************************
// Flag register fields
// ****************************************
`define PLC_FLG_LOCKIF 0
`define PLC_FLG_FALLBACK_IRQ_FLAG 1
`define PLC_FLG_LOCK 2
`define PLC_FLG_FALLBACK_ACTIVE_FLAG 3

// ****************************************
// Reset values, timing and field limits
// ****************************************
`define PLC_CTRL_RST 10'h041
`define PLC_CNT_MID 13'h1000
`define PLC_MULT_MAX 6'h3f
`define PLC_DIV_MAX 3'h7

`endif

// [logic/plc_pkg.sv]
// Types for the loop and fallback clock control block
package plc_pkg;
    typedef enum logic [1:0] {
        PLC_POR,
        PLC_RUN,
        PLC_FALLBACK,
        PLC_MONRST
    } plc_state_t;
endpackage

// [tb/plc_src_model.sv]
// Behavioural external clock source, clock monitor and lock detector
`timescale 1ns/100ps
`default_nettype none

module plc_src_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_on,
    input wire logic lock_on,
    input wire logic trk_on,
    output logic clock_present,
    output logic lock_window_raw,
    output logic track_window_raw,
    output logic tick_enable
);
    // ****************************************
    // Monitor and detector levels, one tick per cycle
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_present <= 1'b0;
            lock_window_raw <= 1'b0;
            track_window_raw <= 1'b0;
            tick_enable <= 1'b0;
        end else begin
            clock_present <= clk_on;
            lock_window_raw <= lock_on;
            track_window_raw <= trk_on;
            tick_enable <= 1'b1;
        end
    end
endmodule // plc_src_model

`default_nettype wire

// [tb/pll_lock_and_limp_home_control_test.sv]
// Self-checking bench for the loop and fallback clock control block
`timescale 1ns/100ps
`default_nettype none
`include "plc_defines.svh"

module pll_lock_and_limp_home_control_test;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, v;
    logic pready, pslverr, loop_supply = 1'b1, normal_mode = 1'b1, stop_mode = 1'b0, wait_mode = 1'b0;
    logic clk_on = 1'b1, lock_on = 1'b0, trk_on = 1'b0;
    logic clock_present, lock_window_raw, track_window_raw, tick_enable;
    logic loop_enable, filter_tracking, bus_clock_from_loop, module_clock_select, min_freq_clocks;
    logic monitor_active, monitor_reset, internal_reset, lock_irq, fallback_irq;
    logic [2:0] ref_divide;
    logic [5:0] loop_multiply;
    int miscompares = 0, compares = 0, cycles = 0, n;
    typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} plc_row_t;
    plc_row_t rows [4] = '{'{`PLC_OFF_SYN, 32'h3f, 32'h3f}, '{`PLC_OFF_REFDV, 32'h7, 32'h7},
        '{`PLC_OFF_REFDV, 32'h3, 32'h3}, '{12'h014, 32'hff, 32'h0}};

    always #10 pclk = ~pclk;

    plc_src_model u_src (.pclk(pclk), .presetn(presetn), .clk_on(clk_on), .lock_on(lock_on), .trk_on(trk_on),
        .clock_present(clock_present), .lock_window_raw(lock_window_raw),
        .track_window_raw(track_window_raw), .tick_enable(tick_enable));

    plc_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .loop_supply(loop_supply), .normal_mode(normal_mode), .stop_mode(stop_mode), .wait_mode(wait_mode),
        .clock_present(clock_present), .lock_window_raw(lock_window_raw),
        .track_window_raw(track_window_raw), .tick_enable(tick_enable), .loop_enable(loop_enable),
        .filter_tracking(filter_tracking), .bus_clock_from_loop(bus_clock_from_loop),
        .module_clock_select(module_clock_select), .min_freq_clocks(min_freq_clocks),
        .monitor_active(monitor_active), .monitor_reset(monitor_reset), .internal_reset(internal_reset),
        .ref_divide(ref_divide), .loop_multiply(loop_multiply), .lock_irq(lock_irq),
        .fallback_irq(fallback_irq));

    // ****************************************
    // Reporting and bus tasks
    // ****************************************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        v = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, v);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge pclk);
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            stop_test();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        cyc(2);
        chk("reset_hold", 1, internal_reset);
        rdc("ctrl_reset", `PLC_OFF_CTRL, 32'h041);
        for (n = 0; n < 5000 && internal_reset !== 1'b0; n++) cyc(1);
        chk("por_length", 1, n > 4000);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, rows[i].a, rows[i].w);
            rdc("row", rows[i].a, rows[i].e);
        end
        chk("divide", 3'h3, ref_divide);
        chk("multiply", 6'h3f, loop_multiply);
        apb(1'b1, `PLC_OFF_CTRL, 32'h041);
        apb(1'b1, `PLC_OFF_CTRL, 32'h045);
        rdc("manual_trk", `PLC_OFF_CTRL, 32'h045);
        chk("manual_filter", 1, filter_tracking);
        apb(1'b1, `PLC_OFF_CTRL, 32'h047);
        rdc("auto_acq", `PLC_OFF_CTRL, 32'h043);
        chk("auto_filter0", 0, filter_tracking);
        trk_on <= 1'b1;
        cyc(8);
        rdc("auto_trk", `PLC_OFF_CTRL, 32'h047);
        chk("auto_filter1", 1, filter_tracking);
        apb(1'b1, `PLC_OFF_CTRL, 32'h143);
        lock_on <= 1'b1;
        cyc(8);
        rdc("lock_set", `PLC_OFF_FLAG, 32'h005);
        chk("lock_irq1", 1, lock_irq);
        apb(1'b1, `PLC_OFF_FLAG, 32'h1);
        cyc(1);
        chk("lock_irq0", 0, lock_irq);
        @(posedge pclk);
        lock_on <= 1'b0;
        cyc(8);
        chk("lock_irq_fall", 1, lock_irq);
        apb(1'b1, `PLC_OFF_FLAG, 32'h3);
        apb(1'b1, `PLC_OFF_CTRL, 32'h251);
        clk_on <= 1'b0;
        cyc(10);
        chk("fb_bus_clock_from_loop", 1, bus_clock_from_loop);
        chk("fb_mcs", 0, module_clock_select);
        chk("fb_on", 1, loop_enable);
        chk("fb_min", 1, min_freq_clocks);
        chk("fb_mon", 1, monitor_active);
        chk("fb_irq", 1, fallback_irq);
        rdc("fb_flag", `PLC_OFF_FLAG, 32'h00a);
        apb(1'b1, `PLC_OFF_FLAG, 32'h2);
        cyc(1);
        chk("fb_irq_clr", 0, fallback_irq);
        apb(1'b1, `PLC_OFF_CTRL, 32'h251);
        @(posedge pclk);
        clk_on <= 1'b1;
        for (n = 0; n < 8300 && min_freq_clocks !== 1'b0; n++) cyc(1);
        chk("fb_exit", 0, min_freq_clocks);
        chk("fb_mcs_back", 1, module_clock_select);
        chk("fb_bus_clock_from_loop_back", 0, bus_clock_from_loop);
        rdc("fb_exit_flag", `PLC_OFF_FLAG, 32'h002);
        apb(1'b1, `PLC_OFF_FLAG, 32'h3);
        apb(1'b1, `PLC_OFF_CTRL, 32'h061);
        clk_on <= 1'b0;
        cyc(10);
        chk("mr_latch", 1, monitor_reset);
        chk("mr_reset", 1, internal_reset);
        @(posedge pclk);
        clk_on <= 1'b1;
        for (n = 0; n < 100 && monitor_reset !== 1'b0; n++) cyc(1);
        chk("mr_release", 0, monitor_reset);
        for (n = 0; n < 9000 && internal_reset !== 1'b0; n++) cyc(1);
        rdc("mr_ctrl", `PLC_OFF_CTRL, 32'h041);
        wait_mode <= 1'b1;
        cyc(4);
        chk("wait_loop", 1, loop_enable);
        @(posedge pclk);
        stop_mode <= 1'b1;
        cyc(2);
        chk("stop_loop", 0, loop_enable);
        chk("ready", 1, pready);
        chk("no_error", 0, pslverr);
        @(posedge pclk);
        stop_mode <= 1'b0;
        clk_on <= 1'b0;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        cyc(2);
        chk("reset2_hold", 1, internal_reset);
        for (n = 0; n < 5000 && internal_reset !== 1'b0; n++) cyc(1);
        chk("por_fallback", 1, min_freq_clocks);
        chk("por_fb_bus_clock_from_loop", 1, bus_clock_from_loop);
        rdc("por_fb_flag", `PLC_OFF_FLAG, 32'h00a);
        stop_test();
    end
endmodule // pll_lock_and_limp_home_control_test

`default_nettype wire
